// >>> hdl/adc_conversion_flow_control.sv
// Conversion flow control: request bits, overrun handling, error flags.
// Assumes one AHB-Lite master, zero-wait slave, requests also from hw pins.
//
// Overview of operation
// - Restart loads first command, swapping buffers on load-ok.
// - Abort stops conversion, sequence and list processing.
// - Restart with abort suppresses restart, load-ok errors.
// - Trigger, or restart in trigger mode, starts sequence.
// - Restart mode: restart plus trigger sets trigger error.
// - Restart overrun held, replayed one clock after clear.
// - Trigger overrun halts at boundary, sets trigger error.
// - Abort while abort flag set is discarded.
// - Restart overrun captures load-ok into background bit.
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module adc_conversion_flow_control
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        hwRestartReq,
  input  wire logic        hwTriggerReq,
  input  wire logic        hwAbortReq,
  input  wire logic        hwLoadOkReq,
  input  wire logic        restartDone,
  input  wire logic        sequenceDone,
  input  wire logic        abortDone,
  input  wire logic        convBoundary,
  output logic             swapBuf,
  output logic             loadFirstCmd,
  output logic             startSeq,
  output logic             abortAll,
  output logic             haltConv,
  output logic             irq
);
  import adc_flow_pkg::*;

  logic                 wrPend_q, wrPend_d;
  logic [AddrWidth-1:0] wrAddr_q, wrAddr_d;
  logic [31:0]          rdata_q, rdata_d;
  logic [IrqWidth-1:0]  intStatus_q, intStatus_d;
  logic [IrqWidth-1:0]  intMask_q, intMask_d;
  flow_mode_t           mode_q, mode_d;
  logic                 restartFlag_q, restartFlag_d;
  logic                 triggerFlag_q, triggerFlag_d;
  logic                 abortFlag_q, abortFlag_d;
  logic                 pendRst_q, pendRst_d;
  logic                 pendLdok_q, pendLdok_d;
  logic                 haltPend_q, haltPend_d;
  logic                 swap_q, load_q, start_q, abort_q, halt_q;

  logic                 addrPhase, ctrlWr;
  logic                 reqRst, reqTrig, reqAbort, reqLdok;
  logic                 rstAccept, rstOverrun, ldokEff, trigAccept, abortAccept;
  logic                 decSwap, decLoad, decStart, decAbort, decAuto, decSupp, decTrigErr;
  logic                 trigOverrun, haltFire;
  logic [IrqWidth-1:0]  irqSet;

  assign addrPhase = hsel && htrans[1] && hready;
  assign ctrlWr    = wrPend_q && (wrAddr_q == OffCtrl);
  assign reqRst    = hwRestartReq || (ctrlWr && hwdata[CtrlRestartBit]);
  assign reqTrig   = hwTriggerReq || (ctrlWr && hwdata[CtrlTriggerBit]);
  assign reqAbort  = hwAbortReq   || (ctrlWr && hwdata[CtrlAbortBit]);
  assign reqLdok   = hwLoadOkReq  || (ctrlWr && hwdata[CtrlLoadOkBit]);

  // A held restart is served in the first cycle the restart flag reads clear
  assign rstAccept   = !restartFlag_q && (reqRst || pendRst_q);
  assign rstOverrun  = restartFlag_q && reqRst;
  assign ldokEff     = pendRst_q ? (pendLdok_q || (reqRst && reqLdok)) : reqLdok;
  assign trigAccept  = reqTrig && !triggerFlag_q;
  assign trigOverrun = reqTrig && triggerFlag_q;
  assign abortAccept = reqAbort && !abortFlag_q;
  assign haltFire    = haltPend_q && convBoundary;

  adc_flow_decoder u_decoder
  (
    .restartIn   (rstAccept),
    .triggerIn   (trigAccept),
    .abortIn     (abortAccept),
    .loadOkIn    (rstAccept && ldokEff),
    .mode        (mode_q),
    .swapBuf     (decSwap),
    .loadFirst   (decLoad),
    .startSeq    (decStart),
    .abortAll    (decAbort),
    .autoTrig    (decAuto),
    .suppressErr (decSupp),
    .trigErr     (decTrigErr)
  );

  // Restarting over a running sequence is reported unless an abort comes too
  always_comb
  begin
    irqSet = '0;
    irqSet[IrqTrigErrBit] = decTrigErr || haltFire;
    irqSet[IrqRstErrBit]  = decLoad && triggerFlag_q && !decSupp;
    irqSet[IrqLdokErrBit] = decSwap && triggerFlag_q && !decSupp;
  end

  always_comb
  begin
    restartFlag_d = restartFlag_q;
    triggerFlag_d = triggerFlag_q;
    abortFlag_d   = abortFlag_q;
    pendRst_d     = pendRst_q;
    pendLdok_d    = pendLdok_q;
    haltPend_d    = haltPend_q;
    if (restartDone)
      restartFlag_d = 1'b0;
    if (rstAccept && !decTrigErr)
      restartFlag_d = 1'b1;
    if (rstAccept)
    begin
      pendRst_d  = 1'b0;
      pendLdok_d = 1'b0;
    end
    if (rstOverrun)
    begin
      pendRst_d  = 1'b1;
      pendLdok_d = reqLdok;
    end
    if (sequenceDone || decAbort)
      triggerFlag_d = 1'b0;
    if (decStart)
      triggerFlag_d = 1'b1;
    if (abortDone)
      abortFlag_d = 1'b0;
    if (abortAccept && !decTrigErr)
      abortFlag_d = 1'b1;
    if (convBoundary || decAbort)
      haltPend_d = 1'b0;
    if (trigOverrun)
      haltPend_d = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      restartFlag_q <= 1'b0;
      triggerFlag_q <= 1'b0;
      abortFlag_q   <= 1'b0;
      pendRst_q     <= 1'b0;
      pendLdok_q    <= 1'b0;
      haltPend_q    <= 1'b0;
      swap_q        <= 1'b0;
      load_q        <= 1'b0;
      start_q       <= 1'b0;
      abort_q       <= 1'b0;
      halt_q        <= 1'b0;
    end
    else
    begin
      restartFlag_q <= restartFlag_d;
      triggerFlag_q <= triggerFlag_d;
      abortFlag_q   <= abortFlag_d;
      pendRst_q     <= pendRst_d;
      pendLdok_q    <= pendLdok_d;
      haltPend_q    <= haltPend_d;
      swap_q        <= decSwap;
      load_q        <= decLoad;
      start_q       <= decStart;
      abort_q       <= decAbort;
      halt_q        <= haltFire;
    end
  end

  // Bus slave: zero wait states; reads are captured in the address phase
  always_comb
  begin
    wrPend_d    = addrPhase && hwrite;
    wrAddr_d    = haddr[AddrWidth-1:0];
    rdata_d     = ReadZero;
    intMask_d   = intMask_q;
    mode_d      = mode_q;
    intStatus_d = intStatus_q;
    if (addrPhase && !hwrite)
    begin
      case (haddr[AddrWidth-1:0])
        OffCtrl:
          rdata_d[CtrlModeBit] = (mode_q == MODE_TRIGGER);
        OffFlags:
        begin
          rdata_d[FlgRestartBit]  = restartFlag_q;
          rdata_d[FlgTriggerBit]  = triggerFlag_q;
          rdata_d[FlgAbortBit]    = abortFlag_q;
          rdata_d[FlgPendRstBit]  = pendRst_q;
          rdata_d[FlgPendLdokBit] = pendLdok_q;
          rdata_d[FlgHaltPendBit] = haltPend_q;
          rdata_d[FlgModeBit]     = (mode_q == MODE_TRIGGER);
        end
        OffIntStatus:
        begin
          rdata_d[IrqWidth-1:0] = intStatus_q;
          intStatus_d = '0;
        end
        OffIntMask:
          rdata_d[IrqWidth-1:0] = intMask_q;
        default:
          rdata_d = ReadZero;
      endcase
    end
    // An event in the clearing cycle survives the read
    intStatus_d = intStatus_d | irqSet;
    if (wrPend_q && (wrAddr_q == OffIntMask))
      intMask_d = hwdata[IrqWidth-1:0];
    if (ctrlWr)
      mode_d = hwdata[CtrlModeBit] ? MODE_TRIGGER : MODE_RESTART;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wrPend_q    <= 1'b0;
      wrAddr_q    <= '0;
      rdata_q     <= ReadZero;
      intStatus_q <= '0;
      intMask_q   <= IntMaskReset;
      mode_q      <= MODE_RESTART;
    end
    else
    begin
      wrPend_q    <= wrPend_d;
      wrAddr_q    <= wrAddr_d;
      rdata_q     <= rdata_d;
      intStatus_q <= intStatus_d;
      intMask_q   <= intMask_d;
      mode_q      <= mode_d;
    end
  end

  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = rdata_q;
  assign irq          = |(intStatus_q & intMask_q);
  assign swapBuf      = swap_q;
  assign loadFirstCmd = load_q;
  assign startSeq     = start_q;
  assign abortAll     = abort_q;
  assign haltConv     = halt_q;

  // A held restart must survive every cycle in which the flag still stands
  sequence rstHeld_s;
    pendRst_q && restartFlag_q && !restartDone;
  endsequence
  sequence flagClears_s;
    restartFlag_q && restartDone && pendRst_q;
  endsequence

  load_on_restart_a: assert property (@(posedge clk_sys) disable iff (reset)
    (rstAccept && !decTrigErr) |=> loadFirstCmd && (swapBuf == $past(ldokEff)))
    else $error("restart did not load first command");
  // A restart with the abort may start a fresh sequence behind the abort
  abort_stops_a: assert property (@(posedge clk_sys) disable iff (reset)
    (abortAccept && !decTrigErr) |=> abortAll && (triggerFlag_q == startSeq))
    else $error("abort did not stop sequence");
  err_suppress_a: assert property (@(posedge clk_sys) disable iff (reset)
    (rstAccept && abortAccept) |=> !intStatus_q[IrqRstErrBit] || $past(intStatus_q[IrqRstErrBit]))
    else $error("restart error raised despite abort");
  auto_trigger_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
    (rstAccept && mode_q == MODE_TRIGGER) |=> triggerFlag_q && startSeq)
    else $error("trigger mode restart did not start sequence");
  trigger_flag_err_a: assert property (@(posedge clk_sys) disable iff (reset)
    (rstAccept && trigAccept && mode_q == MODE_RESTART) |=> intStatus_q[IrqTrigErrBit] && !startSeq)
    else $error("restart with trigger did not flag error");
  held_slot_a: assert property (@(posedge clk_sys) disable iff (reset)
    rstHeld_s |=> pendRst_q && restartFlag_q)
    else $error("held restart lost while restart flag set");
  replay_a: assert property (@(posedge clk_sys) disable iff (reset)
    flagClears_s |=> !restartFlag_q ##1 restartFlag_q && !pendRst_q)
    else $error("held restart not replayed one clock later");
  halt_boundary_a: assert property (@(posedge clk_sys) disable iff (reset)
    (haltPend_q && convBoundary) |=> haltConv && intStatus_q[IrqTrigErrBit])
    else $error("trigger overrun did not halt at boundary");
  abort_discard_a: assert property (@(posedge clk_sys) disable iff (reset)
    (reqAbort && abortFlag_q && !abortDone) |=> abortFlag_q && !abortAll)
    else $error("repeated abort had an effect");
  load_ok_flag_capture_a: assert property (@(posedge clk_sys) disable iff (reset)
    (rstOverrun && !rstAccept) |=> pendRst_q && (pendLdok_q == $past(reqLdok)))
    else $error("load-ok not captured on restart overrun");

endmodule

// >>> hdl/adc_flow_pkg.sv
// Constants shared by the conversion flow control block and its decoder.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package adc_flow_pkg;

  localparam int          AddrWidth      = 4;
  localparam logic [3:0]  OffCtrl        = 4'h0;
  localparam logic [3:0]  OffFlags       = 4'h4;
  localparam logic [3:0]  OffIntStatus   = 4'h8;
  localparam logic [3:0]  OffIntMask     = 4'hC;

  // Control register fields; request bits are write-one strobes
  localparam int          CtrlRestartBit = 0;
  localparam int          CtrlTriggerBit = 1;
  localparam int          CtrlAbortBit   = 2;
  localparam int          CtrlLoadOkBit  = 3;
  localparam int          CtrlModeBit    = 4;

  // Flags register fields
  localparam int          FlgRestartBit  = 0;
  localparam int          FlgTriggerBit  = 1;
  localparam int          FlgAbortBit    = 2;
  localparam int          FlgPendRstBit  = 3;
  localparam int          FlgPendLdokBit = 4;
  localparam int          FlgHaltPendBit = 5;
  localparam int          FlgModeBit     = 6;

  // Interrupt status and mask fields
  localparam int          IrqWidth       = 3;
  localparam int          IrqTrigErrBit  = 0;
  localparam int          IrqRstErrBit   = 1;
  localparam int          IrqLdokErrBit  = 2;

  localparam logic [IrqWidth-1:0] IntMaskReset = 3'h0;
  localparam logic [31:0]         ReadZero     = 32'h0000_0000;

  typedef enum logic
  {
    MODE_RESTART,
    MODE_TRIGGER
  } flow_mode_t;

endpackage

// >>> hdl/adc_flow_decoder.sv
// Decodes one cycle's accepted flow bits into converter actions.
// Purely combinational; the caller presents only bits that were accepted.
`timescale 1ns/100ps
module adc_flow_decoder
(
  input  wire logic                restartIn,
  input  wire logic                triggerIn,
  input  wire logic                abortIn,
  input  wire logic                loadOkIn,
  input  wire adc_flow_pkg::flow_mode_t mode,
  output logic                     swapBuf,
  output logic                     loadFirst,
  output logic                     startSeq,
  output logic                     abortAll,
  output logic                     autoTrig,
  output logic                     suppressErr,
  output logic                     trigErr
);
  import adc_flow_pkg::*;

  always_comb
  begin
    trigErr     = (mode == MODE_RESTART) && restartIn && triggerIn;
    swapBuf     = !trigErr && restartIn && loadOkIn;
    loadFirst   = !trigErr && restartIn;
    abortAll    = !trigErr && abortIn;
    autoTrig    = !trigErr && restartIn && (mode == MODE_TRIGGER);
    startSeq    = !trigErr && (triggerIn || autoTrig);
    suppressErr = restartIn && abortIn;
    // Load-ok alone cannot occur; trigger with abort and no restart both aborts and starts a sequence
  end

endmodule

// >>> sim/flow_partner.sv
// Converter-side model: answers action pulses with done pulses after a delay.
// Assumes one clock and the synchronous reset of the flow block.
`timescale 1ns/100ps
module flow_partner
#(
  parameter int Dly = 30
)
(
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic loadFirstCmd,
  input  wire logic startSeq,
  input  wire logic abortAll,
  output logic      restartDone,
  output logic      sequenceDone,
  output logic      abortDone,
  output logic      convBoundary
);
  int rstQ;
  int seqQ;
  int abtQ;

  // Sequences run twice as long as restarts, so the trigger flag outlives them
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rstQ <= 0;
      seqQ <= 0;
      abtQ <= 0;
    end
    else
    begin
      rstQ <= loadFirstCmd ? Dly : (rstQ > 0 ? rstQ - 1 : 0);
      // A start that comes with an abort runs a fresh sequence after the abort
      seqQ <= startSeq ? 2 * Dly : (abortAll ? 0 : (seqQ > 0 ? seqQ - 1 : 0));
      abtQ <= abortAll ? Dly : (abtQ > 0 ? abtQ - 1 : 0);
    end
  end

  assign restartDone  = (rstQ == 1);
  assign sequenceDone = (seqQ == 1);
  assign abortDone    = (abtQ == 1);
  assign convBoundary = (seqQ > 1) && (seqQ % 4 == 0);
endmodule

// >>> sim/tb.sv
// Self-checking bench for the conversion flow control block.
// Assumes the zero-wait AHB-Lite slave and the flow_partner converter model.
`timescale 1ns/100ps
module tb;
  import adc_flow_pkg::*;
  logic        clk_sys, reset, hsel, hwrite, hreadyout, hresp, irq, rdPh, lo;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic        hwRestartReq, hwTriggerReq, hwAbortReq, hwLoadOkReq;
  logic        restartDone, sequenceDone, abortDone, convBoundary;
  logic        swapBuf, loadFirstCmd, startSeq, abortAll, haltConv;
  logic [63:0] expQ[$];
  logic [63:0] note;
  logic [3:0]  pairs [4] = '{4'h3, 4'h7, 4'hB, 4'hF};
  int          fails, totalChecks, swapN, loadN, seqN, abortN, haltN, rDoneN, aDoneN, base;
  int          sDoneN;
  int          seed = 32'hb788_9013;

  adc_conversion_flow_control i_dut (.clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .hwRestartReq,
    .hwTriggerReq, .hwAbortReq, .hwLoadOkReq, .restartDone, .sequenceDone, .abortDone,
    .convBoundary, .swapBuf, .loadFirstCmd, .startSeq, .abortAll, .haltConv, .irq);
  flow_partner i_partner (.clk_sys, .reset, .loadFirstCmd, .startSeq, .abortAll,
    .restartDone, .sequenceDone, .abortDone, .convBoundary);

  always #5 clk_sys = ~clk_sys;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    totalChecks++;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask

  // Read results are compared where they appear, in the data phase
  always @(posedge clk_sys)
  begin
    if (rdPh)
    begin
      note = expQ.pop_front();
      chk("hrdata", note[31:0], hrdata & note[63:32]);
      chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    end
    rdPh <= hsel && htrans[1] && !hwrite && hreadyout;
    if (!reset)
    begin
      swapN += (swapBuf === 1'b1);
      loadN += (loadFirstCmd === 1'b1);
      seqN += (startSeq === 1'b1);
      abortN += (abortAll === 1'b1);
      haltN += (haltConv === 1'b1);
      rDoneN += restartDone;
      aDoneN += abortDone;
      sDoneN += sequenceDone;
    end
  end

  task automatic waitRdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      fails++;
      give_verdict;
    end
  endtask

  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {28'h000_0000, a};
    waitRdy;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    waitRdy;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    expQ.push_back({m, e});
    xfer(1'b0, a, ReadZero);
  endtask

  task automatic waitFor(ref int c, input int n);
    int k;
    k = 0;
    while (c < n && k < 300)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (c < n)
    begin
      fails++;
      give_verdict;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    give_verdict;
  end

  initial
  begin
    clk_sys = 1'b0;
    reset = 1'b1;
    {hsel, hwrite, rdPh, hwRestartReq, hwTriggerReq, hwAbortReq, hwLoadOkReq} = '0;
    {haddr, hwdata, htrans} = '0;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    rd(OffFlags, ReadZero);
    rd(OffIntStatus, ReadZero);
    rd(OffIntMask, ReadZero);
    wr(OffCtrl, 32'h0000_0009);
    rd(OffFlags, 32'h0000_0001);
    wr(OffCtrl, 32'h0000_0009);
    rd(OffFlags, 32'h0000_0019);
    waitFor(loadN, 2);
    chk("swapBuf", 2, swapN);
    rd(OffFlags, 32'h0000_0001);
    waitFor(rDoneN, 2);
    for (int i = 0; i < 4; i++)
    begin
      wr(OffCtrl, {28'h000_0000, pairs[i]});
      rd(OffIntStatus, 32'h0000_0001);
    end
    chk("loadFirstCmd", 2, loadN);
    wr(OffIntMask, 32'h0000_0001);
    rd(OffIntMask, 32'h0000_0001);
    wr(OffCtrl, 32'h0000_0003);
    idle(1);
    chk("irq", 1, irq);
    rd(OffIntStatus, 32'h0000_0001);
    idle(1);
    chk("irq", 0, irq);
    wr(OffIntMask, ReadZero);
    wr(OffCtrl, 32'h0000_0003);
    idle(1);
    chk("irq", 0, irq);
    rd(OffIntStatus, 32'h0000_0001);
    wr(OffCtrl, 32'h0000_0010);
    rd(OffFlags, 32'h0000_0040);
    lo = $random(seed) & 1;
    hwRestartReq <= 1'b1;
    hwLoadOkReq <= lo;
    @(posedge clk_sys);
    hwRestartReq <= 1'b0;
    hwLoadOkReq <= 1'b0;
    waitFor(seqN, 1);
    chk("swapBuf", 2 + lo, swapN);
    rd(OffFlags, 32'h0000_0043);
    wr(OffCtrl, 32'h0000_0012);
    waitFor(haltN, 1);
    rd(OffIntStatus, 32'h0000_0001);
    waitFor(rDoneN, 3);
    base = abortN;
    wr(OffCtrl, 32'h0000_0015);
    waitFor(abortN, base + 1);
    wr(OffCtrl, 32'h0000_0014);
    idle(3);
    chk("abortAll", base + 1, abortN);
    rd(OffIntStatus, ReadZero, 32'h0000_0006);
    waitFor(aDoneN, abortN);
    waitFor(sDoneN, 1);
    base = seqN;
    hwTriggerReq <= 1'b1;
    @(posedge clk_sys);
    hwTriggerReq <= 1'b0;
    waitFor(seqN, base + 1);
    idle(2);
    give_verdict;
  end
endmodule
